// ==== board_clock_model.sv ====
/*
 * board_clock_model: board oscillator and pll stand-in; free-running host
 * and agent clock pins plus one-cycle pll tick pulses.
 * assumes: one control clock; every rate is a whole number of clk cycles.
 */
`timescale 1ns/1ns
module board_clock_model
	import clkdist_pkg::*;
#(
	parameter int HOST_HALF  = 2,
	parameter int AGENT_HALF = 3,
	parameter int CSB_PER    = 2,
	parameter int DDR_PER    = 3,
	parameter int LBC_PER    = 2
)
(
	input  wire logic clk,
	input  wire logic nrst,
	output logic      host_clock_input,
	output logic      agent_clock_input,
	output pll_tick_t pll_tick
);
	int cnt_r; // free running cycle count

	// cycle counter, launched just after each edge
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			cnt_r <= 0;
		else
			cnt_r <= cnt_r + 1;
	end

	// pins keep fixed half periods, oscillator stops only while nrst is low
	assign host_clock_input  = 1'((cnt_r / HOST_HALF) % 2);
	assign agent_clock_input = 1'((cnt_r / AGENT_HALF) % 2);
	assign pll_tick.csb = (cnt_r % CSB_PER) == 0;
	assign pll_tick.ddr = (cnt_r % DDR_PER) == 0;
	assign pll_tick.lbc = (cnt_r % LBC_PER) == 0;
endmodule

// ==== clkdist_pkg.sv ====
/*
 * clkdist_pkg: constants, enums and structs shared by the system clock
 * distribution block and its unit clock divider.
 * assumes: one 25 MHz control clock; the analog PLLs sit outside and take
 * the ratio codes this block presents.
 */
package clkdist_pkg;

	// control clock
	localparam int unsigned CLK_PERIOD_NS = 40;

	// register offsets (byte addresses on the plain register port)
	localparam logic [7:0] OFS_OUTPUT_CLOCK_CONTROL    = 8'h00;
	localparam logic [7:0] OFS_LOCAL_BUS_CLOCK_CONTROL = 8'h04;
	localparam logic [7:0] OFS_SYSTEM_CLOCK_CONTROL    = 8'h08;
	localparam logic [7:0] OFS_CLOCK_STATUS            = 8'h0C;
	localparam logic [7:0] OFS_RESET_CONFIG_WORD_LOW   = 8'h10;

	// counts and widths
	localparam int unsigned NUM_BUS_CLOCKS = 5;
	localparam int unsigned NUM_UNITS      = 5;
	localparam int unsigned UNIT_PCI_DMA   = 4;

	// reset config word low field positions
	localparam int unsigned RCW_LOCAL_BUS_CLOCK_MODE_BIT    = 31;
	localparam int unsigned RCW_MEMORY_CLOCK_MODE_BIT   = 30;
	localparam int unsigned RCW_SYSTEM_PLL_MULTIPLIER_LSB    = 24;
	localparam int unsigned RCW_PROCESSOR_PLL_RATIO_LSB = 16;

	// hard-coded reset option word (multiplier x4, processor ratio field zero)
	localparam logic [31:0] HARD_RCW_LOW = 32'h0400_2000;

	// system pll multiplier legal codes
	localparam logic [3:0] SYSTEM_PLL_MULTIPLIER_MIN = 4'h2;
	localparam logic [3:0] SYSTEM_PLL_MULTIPLIER_MAX = 4'h6;

	// local bus divider field codes
	localparam logic [1:0] LBDIV_2 = 2'h0;
	localparam logic [1:0] LBDIV_4 = 2'h1;

	// reset values
	localparam logic [4:0]  OUTPUT_CLOCK_CONTROL_RESET     = 5'h00;
	localparam logic [1:0]  LBDIV_RESET    = 2'h0;
	localparam logic [8:0]  SYSTEM_CLOCK_CONTROL_RESET     = 9'h155;
	localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

	// unit clock setting
	typedef enum logic [1:0] {
		UMODE_OFF,
		UMODE_FULL,
		UMODE_HALF,
		UMODE_THIRD
	} unit_mode_t;

	// register port request
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	// ratio codes for the pll macros
	typedef struct packed {
		logic [3:0] csb_mult;
		logic [4:0] ddr_mult;
		logic [4:0] lbc_mult;
		logic [6:0] core_ratio;
		logic       system_pll_multiplier_reserved;
	} pll_cfg_t;

	// tick inputs from the pll macros, one pulse per derived clock period
	typedef struct packed {
		logic csb;
		logic ddr;
		logic lbc;
	} pll_tick_t;

endpackage

// ==== system_clock_distribution.sv ====
/*
 * system_clock_distribution: primary clock select, sync and bus clock
 * outputs, pll ratio codes, memory and local bus clock outputs, and
 * per-unit clock enables, with a plain register port.
 * assumes: clock pins and pll ticks are sampled levels synchronous to clk,
 * clk fast enough to see every level of them; plls are outside.
 */
`timescale 1ns/1ns
// Summary of operation
// RQ1 - primary clock: host pin or agent pin
// RQ2 - host clock feeds halving divider and muxes
// RQ3 - sync output: host clock or half, per strap
// RQ4 - bus clock output n gated by enable n
// RQ5 - bus multiplier: (1 + not strap) times multiplier
// RQ6 - multiplier factors two through six only
// RQ7 - ratios from reset word, pll fed bus clock
// RQ8 - memory clock ratio; output pair halved
// RQ9 - local bus clock ratio then further divider
// RQ10 - local bus output half, quarter or eighth
// RQ11 - units full rate at reset, software selectable
// RQ12 - configurer keeps derived clocks below maxima
// RQ13 - software keeps security, usb below maxima
// RQ14 - multiplier codes 0010..0110 valid, others reserved
// RQ15 - unit rate changes are glitch free
module system_clock_distribution
	import clkdist_pkg::*;
(
	input  wire logic                      clk,
	input  wire logic                      nrst,
	input  wire logic                      host_mode_strap,
	input  wire logic                      input_halving_strap,
	input  wire logic                      rcw_hard_option,
	input  wire logic [31:0]               rcw_low_in,
	input  wire logic                      host_clock_input,
	input  wire logic                      agent_clock_input,
	input  wire pll_tick_t                 pll_tick,
	input  wire reg_req_t                  req,
	output logic [31:0]                    rdata_r,
	output logic                           primary_clock_r,
	output logic                           pci_half_clock_r,
	output logic                           sync_clock_out_r,
	output logic [NUM_BUS_CLOCKS-1:0]      bus_clock_output_r,
	output pll_cfg_t                       pll_cfg_r,
	output logic [1:0]                     memory_clock_out_r,
	output logic [1:0]                     local_bus_clock_out_r,
	output logic [NUM_UNITS-1:0]           unit_clock_en
);

	// configuration captured at reset release
	logic        captured_r;      // straps and word taken
	logic        host_mode_r;     // pci host strap
	logic        halving_r;       // input halving strap level
	logic [31:0] rcw_r;           // reset config word low
	logic        captured_nxt;
	logic        host_mode_nxt;
	logic        halving_nxt;
	logic [31:0] rcw_nxt;

	// software registers
	logic [NUM_BUS_CLOCKS-1:0] output_clock_control_r;   // output_clock_control
	logic [NUM_BUS_CLOCKS-1:0] output_clock_control_nxt;
	logic [1:0]                lbdiv_r;  // local_bus_divider
	logic [1:0]                lbdiv_nxt;
	logic [8:0]                system_clock_control_r;   // system_clock_control
	logic [8:0]                system_clock_control_nxt;
	logic [31:0]               rdata_nxt;

	// clock path state
	logic                      host_prev_r;  // host pin last sample
	logic                      pci_half_nxt;
	logic                      sync_nxt;
	logic [NUM_BUS_CLOCKS-1:0] bus_nxt;
	logic                      prim_nxt;
	logic                      mem_clk_r;    // memory clock phase
	logic                      mem_clk_nxt;
	logic [1:0]                memory_nxt;
	logic [1:0]                lb_cnt_r;     // lbc ticks in half period
	logic [1:0]                lb_cnt_nxt;
	logic                      lb_clk_r;     // local bus clock phase
	logic                      lb_clk_nxt;
	logic [1:0]                local_nxt;
	pll_cfg_t                  pll_cfg_nxt;
	logic                      host_rise;

	// multiplier code to factor, zero for reserved codes
	function automatic logic [3:0] system_pll_multiplier_factor(input logic [3:0] code);
		// RQ14 reserved codes
		if (code >= SYSTEM_PLL_MULTIPLIER_MIN && code <= SYSTEM_PLL_MULTIPLIER_MAX)
			system_pll_multiplier_factor = code;
		else
			system_pll_multiplier_factor = 4'h0;
	endfunction

	// local bus divider field to lbc ticks per half period minus one
	function automatic logic [1:0] lb_half_m1(input logic [1:0] code);
		unique case (code)
			LBDIV_2: lb_half_m1 = 2'd0;
			LBDIV_4: lb_half_m1 = 2'd1;
			default: lb_half_m1 = 2'd3;
		endcase
	endfunction

	// capture straps and reset word once, right after release
	always_comb
	begin
		captured_nxt  = 1'b1;
		host_mode_nxt = host_mode_r;
		halving_nxt   = halving_r;
		rcw_nxt       = rcw_r;
		if (!captured_r)
		begin
			host_mode_nxt = host_mode_strap;
			halving_nxt   = input_halving_strap;
			// RQ7 word source select
			rcw_nxt       = rcw_hard_option ? HARD_RCW_LOW : rcw_low_in;
		end
	end

	// register writes and reads
	always_comb
	begin
		output_clock_control_nxt  = output_clock_control_r;
		lbdiv_nxt = lbdiv_r;
		system_clock_control_nxt  = system_clock_control_r;
		rdata_nxt = RDATA_UNMAPPED;
		if (req.wr)
		begin
			unique case (req.addr)
				OFS_OUTPUT_CLOCK_CONTROL:    output_clock_control_nxt  = req.wdata[NUM_BUS_CLOCKS-1:0];
				OFS_LOCAL_BUS_CLOCK_CONTROL: lbdiv_nxt = req.wdata[1:0];
				// RQ11 software rate select
				OFS_SYSTEM_CLOCK_CONTROL:    system_clock_control_nxt  = req.wdata[8:0];
				default:                     ;
			endcase
		end
		if (req.rd)
		begin
			unique case (req.addr)
				OFS_OUTPUT_CLOCK_CONTROL:    rdata_nxt = {27'h0, output_clock_control_r};
				OFS_LOCAL_BUS_CLOCK_CONTROL: rdata_nxt = {30'h0, lbdiv_r};
				OFS_SYSTEM_CLOCK_CONTROL:    rdata_nxt = {23'h0, system_clock_control_r};
				OFS_CLOCK_STATUS:            rdata_nxt = {28'h0, pll_cfg_r.system_pll_multiplier_reserved,
				                                          halving_r, host_mode_r, captured_r};
				OFS_RESET_CONFIG_WORD_LOW:   rdata_nxt = rcw_r;
				default:                     rdata_nxt = RDATA_UNMAPPED;
			endcase
		end
	end

	// pin clock paths
	assign host_rise = host_clock_input && !host_prev_r;
	always_comb
	begin
		// RQ1 primary source select
		prim_nxt     = host_mode_r ? host_clock_input : agent_clock_input;
		// RQ2 fixed halving divider
		pci_half_nxt = host_rise ? !pci_half_clock_r : pci_half_clock_r;
		// RQ3 sync output mux
		sync_nxt     = halving_r ? host_clock_input : pci_half_nxt;
		// RQ4 per-output gating
		bus_nxt      = output_clock_control_r & {NUM_BUS_CLOCKS{sync_nxt}};
	end

	// ratio codes for the plls
	always_comb
	begin
		logic [3:0] factor;
		logic [4:0] csb5;
		factor = system_pll_multiplier_factor(rcw_r[RCW_SYSTEM_PLL_MULTIPLIER_LSB +: 4]);
		// RQ5 RQ6 bus clock multiplier
		csb5   = halving_r ? {1'b0, factor} : {factor, 1'b0};
		pll_cfg_nxt.csb_mult      = csb5[3:0];
		pll_cfg_nxt.system_pll_multiplier_reserved = (factor == 4'h0);
		// RQ8 memory controller ratio
		pll_cfg_nxt.ddr_mult      = rcw_r[RCW_MEMORY_CLOCK_MODE_BIT] ? {csb5[3:0], 1'b0} : csb5;
		// RQ9 local bus controller ratio
		pll_cfg_nxt.lbc_mult      = rcw_r[RCW_LOCAL_BUS_CLOCK_MODE_BIT] ? {csb5[3:0], 1'b0} : csb5;
		// RQ7 processor pll ratio
		pll_cfg_nxt.core_ratio    = rcw_r[RCW_PROCESSOR_PLL_RATIO_LSB +: 7];
	end

	// memory and local bus output dividers
	always_comb
	begin
		// RQ8 halved memory output pair
		mem_clk_nxt = pll_tick.ddr ? !mem_clk_r : mem_clk_r;
		memory_nxt  = {!mem_clk_nxt, mem_clk_nxt};
		lb_cnt_nxt  = lb_cnt_r;
		lb_clk_nxt  = lb_clk_r;
		if (pll_tick.lbc)
		begin
			// RQ10 half, quarter, eighth
			if (lb_cnt_r >= lb_half_m1(lbdiv_r))
			begin
				lb_cnt_nxt = 2'd0;
				lb_clk_nxt = !lb_clk_r;
			end
			else
			begin
				lb_cnt_nxt = lb_cnt_r + 2'd1;
			end
		end
		local_nxt = {2{lb_clk_nxt}};
	end

	// all registers of the block
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			captured_r            <= 1'b0;
			host_mode_r           <= 1'b0;
			halving_r             <= 1'b0;
			rcw_r                 <= 32'h0000_0000;
			output_clock_control_r                <= OUTPUT_CLOCK_CONTROL_RESET;
			lbdiv_r               <= LBDIV_RESET;
			system_clock_control_r                <= SYSTEM_CLOCK_CONTROL_RESET;
			rdata_r               <= RDATA_UNMAPPED;
			host_prev_r           <= 1'b0;
			primary_clock_r       <= 1'b0;
			pci_half_clock_r      <= 1'b0;
			sync_clock_out_r      <= 1'b0;
			bus_clock_output_r    <= '0;
			pll_cfg_r             <= '0;
			mem_clk_r             <= 1'b0;
			memory_clock_out_r    <= 2'h2;
			lb_cnt_r              <= 2'd0;
			lb_clk_r              <= 1'b0;
			local_bus_clock_out_r <= 2'h0;
		end
		else
		begin
			captured_r            <= captured_nxt;
			host_mode_r           <= host_mode_nxt;
			halving_r             <= halving_nxt;
			rcw_r                 <= rcw_nxt;
			output_clock_control_r                <= output_clock_control_nxt;
			lbdiv_r               <= lbdiv_nxt;
			system_clock_control_r                <= system_clock_control_nxt;
			rdata_r               <= rdata_nxt;
			host_prev_r           <= host_clock_input;
			primary_clock_r       <= prim_nxt;
			pci_half_clock_r      <= pci_half_nxt;
			sync_clock_out_r      <= sync_nxt;
			bus_clock_output_r    <= bus_nxt;
			pll_cfg_r             <= pll_cfg_nxt;
			mem_clk_r             <= mem_clk_nxt;
			memory_clock_out_r    <= memory_nxt;
			lb_cnt_r              <= lb_cnt_nxt;
			lb_clk_r              <= lb_clk_nxt;
			local_bus_clock_out_r <= local_nxt;
		end
	end

	// per-unit clock enables; pci and dma only off or full
	genvar u;
	generate
		for (u = 0; u < NUM_UNITS; u++)
		begin : g_unit
			unit_mode_t umode;
			if (u == UNIT_PCI_DMA)
			begin : g_pci
				assign umode = system_clock_control_r[2*u] ? UMODE_FULL : UMODE_OFF;
			end
			else
			begin : g_std
				assign umode = unit_mode_t'(system_clock_control_r[2*u +: 2]);
			end
			// RQ11 RQ15 glitch-free unit divider
			unit_clock_divider u_div (
				.clk         (clk),
				.nrst        (nrst),
				.csb_tick    (pll_tick.csb),
				.mode        (umode),
				.unit_tick_r (unit_clock_en[u])
			);
		end
	endgenerate

	// primary follows the host pin in host mode
	prim_sel_a: assert property (@(posedge clk) disable iff (!nrst) // RQ1
		(captured_r && host_mode_r) |=> primary_clock_r == $past(host_clock_input))
		else $error("primary not host pin");

	// halving divider flips on each host rise
	pci_half_a: assert property (@(posedge clk) disable iff (!nrst) // RQ2
		host_rise |=> pci_half_clock_r != $past(pci_half_clock_r))
		else $error("halving divider missed edge");

	// strap high passes host clock undivided
	sync_mux_a: assert property (@(posedge clk) disable iff (!nrst) // RQ3
		(captured_r && halving_r) |=> sync_clock_out_r == $past(host_clock_input))
		else $error("sync not undivided host clock");

	// disabled bus clock outputs stay low
	bus_gate_a: assert property (@(posedge clk) disable iff (!nrst) // RQ4
		1'b1 |=> (bus_clock_output_r & ~$past(output_clock_control_r)) == '0)
		else $error("bus clock out while disabled");

	// bus multiplier doubles when strap low
	csb_mult_a: assert property (@(posedge clk) disable iff (!nrst) // RQ5
		(captured_r && !halving_r && $stable(rcw_r)) |=>
		pll_cfg_r.csb_mult == {system_pll_multiplier_factor($past(rcw_r[RCW_SYSTEM_PLL_MULTIPLIER_LSB +: 4])), 1'b0} % 16)
		else $error("bus multiplier wrong");

	// multiplier codes above the maximum flagged as reserved
	system_pll_multiplier_rsv_a: assert property (@(posedge clk) disable iff (!nrst) // RQ14
		(captured_r && rcw_r[RCW_SYSTEM_PLL_MULTIPLIER_LSB +: 4] > SYSTEM_PLL_MULTIPLIER_MAX) |=> pll_cfg_r.system_pll_multiplier_reserved)
		else $error("reserved multiplier not flagged");

	// memory output toggles on every ddr tick
	mem_half_a: assert property (@(posedge clk) disable iff (!nrst) // RQ8
		pll_tick.ddr |=> memory_clock_out_r[0] != $past(memory_clock_out_r[0]))
		else $error("memory clock missed tick");

	// local bus output moves only after lbc tick
	lb_div_a: assert property (@(posedge clk) disable iff (!nrst) // RQ10
		$changed(local_bus_clock_out_r) |-> $past(pll_tick.lbc))
		else $error("local bus clock moved without tick");

	cov_host_c: cover property (@(posedge clk) disable iff (!nrst) captured_r && host_mode_r && host_rise);
	cov_lb8_c: cover property (@(posedge clk) disable iff (!nrst) lbdiv_r == 2'h2 && $rose(lb_clk_r));
	cov_bus_c: cover property (@(posedge clk) disable iff (!nrst) bus_clock_output_r[0] && sync_clock_out_r);

endmodule

// ==== system_clock_distribution_tb.sv ====
/*
 * system_clock_distribution_tb: self-checking bench for the clock block.
 * assumes: board_clock_model drives pins and ticks; bench owns straps,
 * reset word and register port.
 */
`timescale 1ns/1ns
module system_clock_distribution_tb
	import clkdist_pkg::*;
;
	localparam int CSB_PER = 2; // csb tick spacing
	localparam int LBC_PER = 2; // lbc tick spacing
	logic                      clk, nrst, host_mode_strap, input_halving_strap, rcw_hard_option;
	logic [31:0]               rcw_low_in, rdata_r;
	logic                      host_clock_input, agent_clock_input;
	pll_tick_t                 pll_tick;
	reg_req_t                  req;
	logic                      primary_clock_r, pci_half_clock_r, sync_clock_out_r;
	logic [NUM_BUS_CLOCKS-1:0] bus_clock_output_r;
	pll_cfg_t                  pll_cfg_r;
	logic [1:0]                memory_clock_out_r, local_bus_clock_out_r;
	logic [NUM_UNITS-1:0]      unit_clock_en;
	int                        bad_count, checks;

	// control clock
	always #(CLK_PERIOD_NS / 2) clk = ~clk;

	system_clock_distribution DUT (.clk(clk), .nrst(nrst), .host_mode_strap(host_mode_strap),
		.input_halving_strap(input_halving_strap), .rcw_hard_option(rcw_hard_option),
		.rcw_low_in(rcw_low_in), .host_clock_input(host_clock_input),
		.agent_clock_input(agent_clock_input), .pll_tick(pll_tick), .req(req), .rdata_r(rdata_r),
		.primary_clock_r(primary_clock_r), .pci_half_clock_r(pci_half_clock_r),
		.sync_clock_out_r(sync_clock_out_r), .bus_clock_output_r(bus_clock_output_r),
		.pll_cfg_r(pll_cfg_r), .memory_clock_out_r(memory_clock_out_r),
		.local_bus_clock_out_r(local_bus_clock_out_r), .unit_clock_en(unit_clock_en));

	board_clock_model #(.CSB_PER(CSB_PER), .LBC_PER(LBC_PER)) board (.clk(clk), .nrst(nrst),
		.host_clock_input(host_clock_input), .agent_clock_input(agent_clock_input),
		.pll_tick(pll_tick));

	// verdict and end of run
	task wrap_up;
		if (bad_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// one comparison, counted
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// one-cycle register write
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req <= '0;
	endtask

	// one-cycle read, data judged in the following cycle
	task rd(input logic [7:0] a, input logic [31:0] exp, input string name);
		@(posedge clk);
		req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req <= '0;
		#1 chk(name, exp, rdata_r);
	endtask

	// reset with new straps; outputs idle while held
	task do_reset(input logic host, input logic halve, input logic hard, input logic [31:0] word);
		@(posedge clk);
		nrst <= 1'b0;
		host_mode_strap <= host;
		input_halving_strap <= halve;
		rcw_hard_option <= hard;
		rcw_low_in <= word;
		repeat (2) @(posedge clk);
		#1 chk("reset_out", 32'h0000_0002, {primary_clock_r, sync_clock_out_r, bus_clock_output_r,
			local_bus_clock_out_r, unit_clock_en, memory_clock_out_r});
		@(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
	endtask

	// observed signal by index; 10 and up are unit enables
	function automatic logic pick(int s);
		case (s)
			0: return primary_clock_r;
			1: return pci_half_clock_r;
			2: return sync_clock_out_r;
			3: return memory_clock_out_r[0];
			4: return local_bus_clock_out_r[0];
			default: return unit_clock_en[s-10];
		endcase
	endfunction

	// cycles to next toggle, or next pulse for unit enables
	task wait_ev(input int s, output int n);
		logic p;
		p = pick(s);
		n = 0;
		do
			@(posedge clk) #1 n++;
		while (n < 40 && (s >= 10 ? pick(s) !== 1'b1 : pick(s) === p));
	endtask

	// spacing between two events
	task gap(input int s, input int exp, input string name);
		int n;
		wait_ev(s, n);
		wait_ev(s, n);
		chk(name, exp, n);
	endtask

	// registers, reset values, read-only and unmapped places, ratio codes
	task t_regs;
		rd(OFS_SYSTEM_CLOCK_CONTROL, {23'h0, SYSTEM_CLOCK_CONTROL_RESET}, "system_clock_control");
		rd(OFS_OUTPUT_CLOCK_CONTROL, 32'h0000_0000, "output_clock_control");
		rd(OFS_CLOCK_STATUS, 32'h0000_0007, "status");
		wr(OFS_RESET_CONFIG_WORD_LOW, 32'hFFFF_FFFF);
		rd(OFS_RESET_CONFIG_WORD_LOW, 32'hC500_0000, "rcw");
		wr(8'h40, 32'hFFFF_FFFF);
		rd(8'h40, 32'h0000_0000, "unmapped");
		chk("pll_cfg", {4'h5, 5'h0A, 5'h0A, 7'h00, 1'h0}, pll_cfg_r);
	endtask

	// host pin paths and gated bus outputs
	task t_host;
		gap(0, 2, "primary");
		gap(1, 4, "pci_half");
		gap(2, 2, "sync_full");
		chk("bus_off", 32'h0000_0000, bus_clock_output_r);
		wr(OFS_OUTPUT_CLOCK_CONTROL, 32'h0000_0005);
		repeat (8)
		begin
			@(posedge clk) #1;
			chk("bus_out", {2'h0, sync_clock_out_r, 1'h0, sync_clock_out_r}, bus_clock_output_r);
		end
	endtask

	// memory pair and local bus divider settings
	task t_memlb;
		int d;
		gap(3, 3, "mem_p");
		chk("mem_pair", !memory_clock_out_r[0], memory_clock_out_r[1]);
		for (d = 0; d < 4; d++)
		begin
			wr(OFS_LOCAL_BUS_CLOCK_CONTROL, d);
			repeat (10) @(posedge clk);
			gap(4, LBC_PER * (d == 0 ? 1 : d == 1 ? 2 : 4), "lb_div");
			chk("lb_pair", local_bus_clock_out_r[0], local_bus_clock_out_r[1]);
		end
	endtask

	// units through full, half, third and off; pci and dma unit through full and off only
	task t_units;
		logic [1:0] m;
		int         i, u, c;
		for (i = 0; i < 4; i++)
		begin
			m = 2'(i + 1);
			wr(OFS_SYSTEM_CLOCK_CONTROL, {23'h0, m == 2'h1, m, m, m, m});
			repeat (8) @(posedge clk);
			for (u = 0; u < NUM_UNITS; u++)
				if (m != 2'h0 && (u < UNIT_PCI_DMA || m == 2'h1))
					gap(10 + u, CSB_PER * m, "unit_rate");
				else
				begin
					c = 0;
					repeat (12) @(posedge clk) #1 c += unit_clock_en[u];
					chk("unit_off", 32'h0000_0000, c);
				end
		end
	endtask

	// agent mode, halved sync, hard-coded word, every multiplier code
	task t_agent;
		int i;
		do_reset(1'b0, 1'b0, 1'b1, 32'h0000_0000);
		rd(OFS_CLOCK_STATUS, 32'h0000_0001, "status_agent");
		gap(0, 3, "primary_agent");
		gap(2, 4, "sync_half");
		rd(OFS_RESET_CONFIG_WORD_LOW, HARD_RCW_LOW, "rcw_hard");
		chk("pll_hard", {4'h8, 5'h08, 5'h08, HARD_RCW_LOW[RCW_PROCESSOR_PLL_RATIO_LSB +: 7], 1'h0}, pll_cfg_r);
		for (i = 0; i < 16; i++)
		begin
			do_reset(1'b1, 1'b1, 1'b0, {4'h0, 4'(i), 24'h0});
			chk("system_pll_multiplier", (i >= 2 && i <= 6) ? i : 0, pll_cfg_r.csb_mult);
			chk("system_pll_multiplier_rsv", !(i >= 2 && i <= 6), pll_cfg_r.system_pll_multiplier_reserved);
		end
	endtask

	// stimulus
	initial
	begin
		clk = 1'b0;
		nrst = 1'b0;
		host_mode_strap = 1'b1;
		input_halving_strap = 1'b1;
		rcw_hard_option = 1'b0;
		rcw_low_in = 32'h0000_0000;
		req = '0;
		bad_count = 0;
		checks = 0;
		do_reset(1'b1, 1'b1, 1'b0, 32'hC500_0000);
		t_regs();
		t_host();
		t_memlb();
		t_units();
		t_agent();
		wrap_up();
	end

	// watchdog against a hang
	initial
	begin
		#(CLK_PERIOD_NS * 20000);
		bad_count++;
		wrap_up();
	end
endmodule

// ==== unit_clock_divider.sv ====
/*
 * unit_clock_divider: turns the system bus clock tick into a unit clock
 * enable at off, full, half or one-third rate.
 * assumes: csb_tick is one clk cycle wide; mode may change at any time.
 */
`timescale 1ns/1ns
module unit_clock_divider
	import clkdist_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       csb_tick,
	input  wire unit_mode_t mode,
	output logic            unit_tick_r
);

	unit_mode_t active_r;   // mode in force for current period
	unit_mode_t active_nxt;
	logic [1:0] cnt_r;      // ticks left in current period
	logic [1:0] cnt_nxt;
	logic       tick_nxt;

	// ticks per unit period minus one
	function automatic logic [1:0] period_m1(input unit_mode_t m);
		unique case (m)
			UMODE_HALF:  period_m1 = 2'd1;
			UMODE_THIRD: period_m1 = 2'd2;
			default:     period_m1 = 2'd0;
		endcase
	endfunction

	// next state: mode only taken at a period boundary
	always_comb
	begin
		active_nxt = active_r;
		cnt_nxt    = cnt_r;
		tick_nxt   = 1'b0;
		if (csb_tick)
		begin
			// RQ15 boundary-only switch
			if (cnt_r == 2'd0)
			begin
				active_nxt = mode;
				cnt_nxt    = period_m1(mode);
				tick_nxt   = (mode != UMODE_OFF);
			end
			else
			begin
				cnt_nxt = cnt_r - 2'd1;
			end
		end
	end

	// registers
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			active_r    <= UMODE_FULL;
			cnt_r       <= 2'd0;
			unit_tick_r <= 1'b0;
		end
		else
		begin
			active_r    <= active_nxt;
			cnt_r       <= cnt_nxt;
			unit_tick_r <= tick_nxt;
		end
	end

	// no tick while off
	unit_off_a: assert property (@(posedge clk) disable iff (!nrst) // RQ11
		(active_nxt == UMODE_OFF) |=> !unit_tick_r)
		else $error("unit tick while off");

	// half rate gives no ticks back to back
	unit_half_a: assert property (@(posedge clk) disable iff (!nrst) // RQ15
		(unit_tick_r && active_r == UMODE_HALF && $stable(active_r)) |=> !unit_tick_r)
		else $error("half rate tick too soon");

	unit_third_c: cover property (@(posedge clk) disable iff (!nrst)
		active_r == UMODE_THIRD && unit_tick_r);

endmodule
